//--- src/qdw_consts.vh
// constants for the queued dma write command engine
`ifndef QDW_CONSTS_VH
`define QDW_CONSTS_VH

// fis kinds requested from the transport layer
`define QDW_FIS_NONE      2'h0
`define QDW_FIS_ACTIVATE  2'h1
`define QDW_FIS_REGISTER  2'h2

// status byte field positions in the register fis
`define QDW_STS_ERR_BIT   0
`define QDW_STS_DRQ_BIT   3
`define QDW_STS_BSY_BIT   7

// reset values
`define QDW_STS_RST       8'h00
`define QDW_ERR_RST       8'h00
`define QDW_CNT_RST       24'h000000

// receive buffer geometry and dword counter width
`define QDW_BUF_WIDTH     32
`define QDW_BUF_DEPTH     4
`define QDW_CNT_WIDTH     24

`endif

//--- src/qdw_fifo.v
// small synchronous fifo for received data dwords
`timescale 1ns/100ps
`default_nettype none

module qdw_fifo
#(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
)
(
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_n_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // level
  output wire             empty_o
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign empty_o     = ~out_valid_o;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  // storage needs no reset, only the pointers and the count do
  always @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end

  // pointers wrap at depth, which must be a power of two
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // qdw_fifo

`default_nettype wire

//--- src/qdw_xfer_cnt.v
// dword counter that tracks received data against the requested length
`timescale 1ns/100ps
`default_nettype none

module qdw_xfer_cnt
#(
  parameter CW = 24
)
(
  // clock and reset
  input  wire          clk_i,
  input  wire          rst_n_i,
  // control
  input  wire          load_i,
  input  wire [CW-1:0] total_i,
  input  wire          inc_i,
  // result
  output wire          done_o,
  output wire [CW-1:0] count_o
);

  reg [CW-1:0] total_q;
  reg [CW-1:0] count_q;

  // done once every requested dword has been taken; overruns stay done
  assign done_o  = (count_q >= total_q);
  assign count_o = count_q;

  // load restarts the count for a new command
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      total_q <= {CW{1'b0}};
      count_q <= {CW{1'b0}};
    end
    else if (load_i)
    begin
      total_q <= total_i;
      count_q <= {CW{1'b0}};
    end
    else if (inc_i && count_q != {CW{1'b1}})
      count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
  end

endmodule // qdw_xfer_cnt

`default_nettype wire

//--- src/qdw_top.v
// command-layer engine for the queued dma write command class
`timescale 1ns/100ps
`default_nettype none
`include "qdw_consts.vh"

module qdw_top
#(
  parameter DATA_W = `QDW_BUF_WIDTH,
  parameter DEPTH  = `QDW_BUF_DEPTH,
  parameter CNT_W  = `QDW_CNT_WIDTH
)
(
  // clock and reset
  input  wire              CLK_I,
  input  wire              RST_N_I,
  // command from the command decoder
  input  wire              CMD_VALID_I,
  output wire              CMD_READY_O,
  input  wire [CNT_W-1:0]  CMD_DWORDS_I,
  input  wire [7:0]        CMD_STATUS_I,
  input  wire [7:0]        CMD_ERROR_I,
  // device conditions
  input  wire              ACCEPT_READY_I,
  input  wire              ABORT_I,
  input  wire              REL_INT_EN_I,
  // fis transmit request to the transport layer
  output wire              TX_REQ_O,
  output wire [1:0]        TX_TYPE_O,
  output wire              TX_BUS_RELEASE_FLAG_O,
  output wire              TX_INT_O,
  output wire [7:0]        TX_STATUS_O,
  output wire [7:0]        TX_ERROR_O,
  input  wire              TX_DONE_I,
  // data fis payload from the transport layer
  input  wire              RX_VALID_I,
  output wire              RX_READY_O,
  input  wire [DATA_W-1:0] RX_DATA_I,
  input  wire              RX_LAST_I,
  // received data towards the media buffer
  output wire              BUF_VALID_O,
  input  wire              BUF_READY_I,
  output wire [DATA_W-1:0] BUF_DATA_O,
  // engine state
  output wire              BUSY_O,
  output wire [2:0]        STATE_O,
  output wire [CNT_W-1:0]  DWORD_COUNT_O
);

  // state codes
  localparam [2:0] device_idle_state         = 3'h0;
  localparam [2:0] queued_write_decide_state = 3'h1;
  localparam [2:0] activate_send_state       = 3'h2;
  localparam [2:0] data_receive_state        = 3'h3;
  localparam [2:0] buffer_prepare_state      = 3'h4;
  localparam [2:0] status_send_state         = 3'h5;
  localparam [2:0] release_send_state        = 3'h6;

  localparam FIFO_AW = (DEPTH <= 2) ? 1 : (DEPTH <= 4) ? 2 : (DEPTH <= 8) ? 3 : 4;

  reg  [2:0]       state_q;
  reg  [2:0]       state_d;
  reg  [7:0]       sts_q;
  reg  [7:0]       sts_d;
  reg  [7:0]       err_q;
  reg  [7:0]       err_d;
  reg              abort_pend_q;
  reg              abort_pend_d;
  reg  [1:0]       tx_type_q;
  reg  [1:0]       tx_type_d;
  reg              tx_rel_q;
  reg              tx_rel_d;
  reg              tx_int_q;
  reg              tx_int_d;
  wire             fifo_in_ready;
  wire             fifo_empty;
  wire             rx_push;
  wire             cnt_done;
  wire             cmd_take;

  // true in the states that hold a fis request open
  function is_send_state;
    input [2:0] st;
    begin
      is_send_state = (st == activate_send_state) || (st == status_send_state) ||
                      (st == release_send_state);
    end
  endfunction

  // status byte for completion: error bit forced on abort, busy and drq cleared
  function [7:0] completion_status;
    input [7:0] base;
    input       aborted;
    reg   [7:0] v;
    begin
      v = base;
      v[`QDW_STS_BSY_BIT] = 1'b0;
      v[`QDW_STS_DRQ_BIT] = 1'b0;
      if (aborted)
        v[`QDW_STS_ERR_BIT] = 1'b1;
      completion_status = v;
    end
  endfunction

  // handshakes are combinational, fis fields come from flops
  assign cmd_take    = CMD_VALID_I && (state_q == device_idle_state);
  assign CMD_READY_O = (state_q == device_idle_state);
  assign TX_REQ_O    = is_send_state(state_q);
  assign TX_TYPE_O   = tx_type_q;
  assign TX_BUS_RELEASE_FLAG_O = tx_rel_q;
  assign TX_INT_O    = tx_int_q;
  assign TX_STATUS_O = sts_q;
  assign TX_ERROR_O  = err_q;
  assign BUSY_O      = (state_q != device_idle_state);
  assign STATE_O     = state_q;

  // data is only taken while a data fis is expected, so none moves outside a transfer
  assign RX_READY_O = (state_q == data_receive_state) && fifo_in_ready;
  assign rx_push    = RX_VALID_I && RX_READY_O;

  // next-state logic
  always @*
  begin
    state_d      = state_q;
    sts_d        = sts_q;
    err_d        = err_q;
    abort_pend_d = abort_pend_q;
    case (state_q)
      device_idle_state:
      begin
        if (cmd_take)
        begin
          state_d      = queued_write_decide_state;
          sts_d        = CMD_STATUS_I;
          err_d        = CMD_ERROR_I;
          abort_pend_d = 1'b0;
        end
      end
      queued_write_decide_state:
      begin
        // an abort outranks readiness: a command aborted here moves no data
        if (ABORT_I)
        begin
          state_d = status_send_state;
          sts_d   = completion_status(sts_q, 1'b1);
        end
        else if (ACCEPT_READY_I)
          state_d = activate_send_state;
        else
          state_d = release_send_state;
      end
      activate_send_state:
      begin
        if (TX_DONE_I)
          state_d = data_receive_state;
      end
      data_receive_state:
      begin
        // an error mid-fis is held and acted on once the fis is complete
        if (ABORT_I)
          abort_pend_d = 1'b1;
        if (rx_push && RX_LAST_I)
          state_d = buffer_prepare_state;
      end
      buffer_prepare_state:
      begin
        // no release path exists from here; the transfer runs to status
        if (abort_pend_q || ABORT_I)
        begin
          state_d      = status_send_state;
          sts_d        = completion_status(sts_q, 1'b1);
          abort_pend_d = 1'b0;
        end
        else if (cnt_done && fifo_empty)
        begin
          state_d = status_send_state;
          sts_d   = completion_status(sts_q, 1'b0);
        end
        else if (!cnt_done && ACCEPT_READY_I)
          state_d = activate_send_state;
      end
      status_send_state:
      begin
        if (TX_DONE_I)
          state_d = device_idle_state;
      end
      release_send_state:
      begin
        if (TX_DONE_I)
          state_d = device_idle_state;
      end
      default:
        state_d = device_idle_state;
    endcase
  end

  // fis fields follow the state being entered so they are stable with the request
  always @*
  begin
    tx_type_d = `QDW_FIS_NONE;
    tx_rel_d  = 1'b0;
    tx_int_d  = 1'b0;
    case (state_d)
      activate_send_state:
        tx_type_d = `QDW_FIS_ACTIVATE;
      status_send_state:
      begin
        tx_type_d = `QDW_FIS_REGISTER;
        tx_int_d  = 1'b1;
      end
      release_send_state:
      begin
        tx_type_d = `QDW_FIS_REGISTER;
        tx_rel_d  = 1'b1;
        tx_int_d  = (state_q == release_send_state) ? tx_int_q : REL_INT_EN_I;
      end
      default:
        tx_type_d = `QDW_FIS_NONE;
    endcase
  end

  // state and field registers
  always @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_q      <= device_idle_state;
      sts_q        <= `QDW_STS_RST;
      err_q        <= `QDW_ERR_RST;
      abort_pend_q <= 1'b0;
      tx_type_q    <= `QDW_FIS_NONE;
      tx_rel_q     <= 1'b0;
      tx_int_q     <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      sts_q        <= sts_d;
      err_q        <= err_d;
      abort_pend_q <= abort_pend_d;
      tx_type_q    <= tx_type_d;
      tx_rel_q     <= tx_rel_d;
      tx_int_q     <= tx_int_d;
    end
  end

  // received dwords are counted against the command's length
  qdw_xfer_cnt
  #(
    .CW (CNT_W)
  )
  u_cnt
  (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .load_i  (cmd_take),
    .total_i (CMD_DWORDS_I),
    .inc_i   (rx_push),
    .done_o  (cnt_done),
    .count_o (DWORD_COUNT_O)
  );

  // buffer stalls the transport layer when the media side is slow
  qdw_fifo
  #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (FIFO_AW)
  )
  u_fifo
  (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .in_valid_i  (RX_VALID_I && (state_q == data_receive_state)),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (RX_DATA_I),
    .out_valid_o (BUF_VALID_O),
    .out_ready_i (BUF_READY_I),
    .out_data_o  (BUF_DATA_O),
    .empty_o     (fifo_empty)
  );

endmodule // qdw_top

`default_nettype wire

//--- test/qdw_top_properties.sv
// port-level checks for the queued dma write engine
`timescale 1ns/100ps
`default_nettype none
module qdw_top_properties (
  // clock and reset
  input wire logic       CLK_I,
  input wire logic       RST_N_I,
  // command and device conditions
  input wire logic       CMD_VALID_I,
  input wire logic       CMD_READY_O,
  input wire logic       ACCEPT_READY_I,
  input wire logic       ABORT_I,
  input wire logic       REL_INT_EN_I,
  // fis requests and data
  input wire logic       TX_REQ_O,
  input wire logic [1:0] TX_TYPE_O,
  input wire logic       TX_BUS_RELEASE_FLAG_O,
  input wire logic       TX_INT_O,
  input wire logic       TX_DONE_I,
  input wire logic       RX_VALID_I,
  input wire logic       RX_READY_O,
  input wire logic       RX_LAST_I,
  input wire logic [2:0] STATE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // steps used by the checks; s_decide and s_sent are shared by several
  sequence s_decide; STATE_O == 3'h1; endsequence
  sequence s_sent; TX_REQ_O && TX_DONE_I; endsequence
  sequence s_rel_fis; STATE_O == 3'h6 && TX_REQ_O && TX_TYPE_O == 2'h2 && TX_BUS_RELEASE_FLAG_O; endsequence
  a_cmd_taken: assert property (CMD_VALID_I && CMD_READY_O |=> s_decide)
    else $error("command not taken");
  a_decide_act: assert property (s_decide ##0 (ACCEPT_READY_I && !ABORT_I)
    |=> STATE_O == 3'h2 && TX_REQ_O && TX_TYPE_O == 2'h1) else $error("no activate");
  a_decide_abort: assert property (s_decide ##0 ABORT_I |=> STATE_O == 3'h5)
    else $error("abort missed");
  a_decide_rel: assert property (s_decide ##0 (!ACCEPT_READY_I && !ABORT_I)
    |=> s_rel_fis ##0 TX_INT_O == $past(REL_INT_EN_I)) else $error("bad release");
  a_act_recv: assert property (STATE_O == 3'h2 ##0 s_sent |=> STATE_O == 3'h3)
    else $error("no receive");
  a_recv_prep: assert property (STATE_O == 3'h3 && RX_VALID_I && RX_READY_O && RX_LAST_I
    |=> STATE_O == 3'h4) else $error("no prepare");
  a_prep_next: assert property (STATE_O == 3'h4 |=> STATE_O inside {3'h2, 3'h4, 3'h5})
    else $error("bad prepare exit");
  a_status_fis: assert property (STATE_O == 3'h5
    |-> TX_REQ_O && TX_TYPE_O == 2'h2 && TX_INT_O && !TX_BUS_RELEASE_FLAG_O) else $error("bad status");
  a_fis_idle: assert property (STATE_O inside {3'h5, 3'h6} ##0 s_sent
    |=> STATE_O == 3'h0 && CMD_READY_O) else $error("no idle");
endmodule // qdw_top_properties
`default_nettype wire

//--- test/qdw_host_model.sv
// transport-side model: answers fis requests, supplies data fis dwords
`timescale 1ns/100ps
`default_nettype none
module qdw_host_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // knobs
  input  wire logic [3:0]  dly_i,
  input  wire logic [3:0]  fis_dw_i,
  // fis requests
  input  wire logic        tx_req_i,
  input  wire logic [1:0]  tx_type_i,
  output logic             tx_done_o,
  // data fis
  input  wire logic        rx_ready_i,
  output logic             rx_valid_o,
  output logic [31:0]      rx_data_o,
  output logic             rx_last_o
);
  logic [3:0]  wait_q;
  logic [3:0]  left_q;
  logic [31:0] seq_q;
  // idle data line shows the inverse so a stale word never matches
  assign rx_valid_o = left_q != 4'h0;
  assign rx_data_o  = rx_valid_o ? (32'h5a000000 | seq_q) : ~(32'h5a000000 | seq_q);
  assign rx_last_o  = left_q == 4'h1;
  // done after dly_i cycles; data only follows its own activate
  always @(posedge clk_i)
  begin
    tx_done_o <= 1'b0;
    if (!rst_n_i)
    begin
      wait_q <= 4'h0;
      left_q <= 4'h0;
      seq_q  <= 32'h0;
    end
    else
    begin
      if (tx_req_i && !tx_done_o && wait_q == dly_i)
      begin
        tx_done_o <= 1'b1;
        wait_q    <= 4'h0;
        if (tx_type_i == 2'h1)
          left_q <= fis_dw_i;
      end
      else if (tx_req_i && !tx_done_o)
        wait_q <= wait_q + 4'h1;
      if (rx_valid_o && rx_ready_i)
      begin
        left_q <= left_q - 4'h1;
        seq_q  <= seq_q + 32'h1;
      end
    end
  end
endmodule // qdw_host_model
`default_nettype wire

//--- test/qdw_top_tb.sv
// self-checking bench for the queued dma write engine
`timescale 1ns/100ps
`default_nettype none
module qdw_top_tb;
  logic        CLK_I, RST_N_I, CMD_VALID_I, ACCEPT_READY_I, ABORT_I, REL_INT_EN_I, BUF_READY_I;
  logic        TX_DONE_I, RX_VALID_I, RX_LAST_I, CMD_READY_O, TX_REQ_O, TX_BUS_RELEASE_FLAG_O;
  logic        TX_INT_O, RX_READY_O, BUF_VALID_O, BUSY_O;
  logic [1:0]  TX_TYPE_O;
  logic [2:0]  STATE_O;
  logic [3:0]  dly;
  logic [7:0]  CMD_STATUS_I, CMD_ERROR_I, TX_STATUS_O, TX_ERROR_O;
  logic [9:0]  last_fis;
  logic [7:0]  last_err;
  logic [23:0] CMD_DWORDS_I, DWORD_COUNT_O;
  logic [31:0] RX_DATA_I, BUF_DATA_O;
  int          fails, n_checks, n_act, e_seq;
  qdw_top dut_u (.CLK_I, .RST_N_I, .CMD_VALID_I, .CMD_READY_O, .CMD_DWORDS_I, .CMD_STATUS_I, .CMD_ERROR_I,
    .ACCEPT_READY_I, .ABORT_I, .REL_INT_EN_I, .TX_REQ_O, .TX_TYPE_O, .TX_BUS_RELEASE_FLAG_O, .TX_INT_O,
    .TX_STATUS_O, .TX_ERROR_O, .TX_DONE_I, .RX_VALID_I, .RX_READY_O, .RX_DATA_I, .RX_LAST_I, .BUF_VALID_O,
    .BUF_READY_I, .BUF_DATA_O, .BUSY_O, .STATE_O, .DWORD_COUNT_O);
  qdw_host_model host_u (.clk_i(CLK_I), .rst_n_i(RST_N_I), .dly_i(dly), .fis_dw_i(4'h4), .tx_req_i(TX_REQ_O),
    .tx_type_i(TX_TYPE_O), .tx_done_o(TX_DONE_I), .rx_ready_i(RX_READY_O), .rx_valid_o(RX_VALID_I),
    .rx_data_o(RX_DATA_I), .rx_last_o(RX_LAST_I));
  // 125 MHz clock
  always #4 CLK_I = ~CLK_I;
  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge CLK_I) #1;
  endtask
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // present one command; conditions stay as levels until the next one
  task t_cmd(input logic acc, input logic ab, input logic ie);
  begin
    {ACCEPT_READY_I, ABORT_I, REL_INT_EN_I} = {acc, ab, ie};
    CMD_VALID_I = 1'b1;
    cyc(1);
    CMD_VALID_I = 1'b0;
  end
  endtask
  // bounded wait for idle; running out counts and ends the run
  task wait_idle;
    int i;
  begin
    for (i = 0; i < 300 && STATE_O !== 3'h0; i++)
      cyc(1);
    chk({BUSY_O, CMD_READY_O, STATE_O}, 5'h08);
    if (STATE_O !== 3'h0)
      stop_test;
  end
  endtask
  task t_release(input logic ie, input logic [3:0] d);
  begin
    dly = d;
    t_cmd(1'b0, 1'b0, ie);
    wait_idle;
    chk(last_fis, {1'b1, ie, 8'hd8});
    chk(last_err, 8'h04);
    $display("release test done");
  end
  endtask
  task t_abort;
  begin
    dly = 4'h2;
    t_cmd(1'b1, 1'b1, 1'b0);
    wait_idle;
    chk(last_fis, 10'h151);
    chk(last_err, 8'h04);
    $display("abort test done");
  end
  endtask
  // two data fis of four dwords, buffer stalled until the fifo refuses
  task t_write;
  begin
    BUF_READY_I = 1'b0;
    t_cmd(1'b1, 1'b0, 1'b0);
    cyc(40);
    chk({STATE_O, RX_READY_O, BUF_VALID_O}, 5'h0d);
    chk(DWORD_COUNT_O, 24'h000004);
    BUF_READY_I = 1'b1;
    wait_idle;
    chk(n_act, 2);
    chk(e_seq, 8);
    chk(last_fis, 10'h150);
    $display("write test done");
  end
  endtask
  // error raised mid data fis: the fis still completes, then status carries the error bit
  task t_wabort;
    int i;
  begin
    dly = 4'h0;
    t_cmd(1'b1, 1'b0, 1'b0);
    for (i = 0; i < 100 && STATE_O !== 3'h3; i++)
      cyc(1);
    chk(STATE_O, 3'h3);
    if (STATE_O !== 3'h3)
      stop_test;
    ABORT_I = 1'b1;
    wait_idle;
    chk(last_fis, 10'h151);
    chk(DWORD_COUNT_O, 24'h000004);
    chk(n_act, 3);
    chk(e_seq, 12);
    $display("write abort test done");
  end
  endtask
  // records sent fis and checks drained data order
  always @(posedge CLK_I)
  begin
    if (TX_REQ_O && TX_DONE_I && TX_TYPE_O == 2'h1)
      n_act <= n_act + 1;
    if (TX_REQ_O && TX_DONE_I && TX_TYPE_O == 2'h2)
    begin
      last_fis <= {TX_BUS_RELEASE_FLAG_O, TX_INT_O, TX_STATUS_O};
      last_err <= TX_ERROR_O;
    end
    if (BUF_VALID_O && BUF_READY_I)
    begin
      chk(BUF_DATA_O, 32'h5a000000 | e_seq);
      e_seq <= e_seq + 1;
    end
  end
  initial
  begin
    {CLK_I, RST_N_I, CMD_VALID_I, ACCEPT_READY_I, ABORT_I, REL_INT_EN_I, BUF_READY_I} = 7'h01;
    {CMD_DWORDS_I, CMD_STATUS_I, CMD_ERROR_I} = {24'h000008, 8'hd8, 8'h04};
    {dly, last_fis, last_err, fails, n_checks, n_act, e_seq} = '0;
    repeat (6) @(posedge CLK_I);
    #1 RST_N_I = 1'b1;
    t_release(1'b0, 4'h0);
    t_release(1'b1, 4'h5);
    t_abort;
    t_write;
    t_wabort;
    stop_test;
  end
endmodule // qdw_top_tb
bind qdw_top qdw_top_properties chk_u (.CLK_I, .RST_N_I, .CMD_VALID_I, .CMD_READY_O, .ACCEPT_READY_I,
  .ABORT_I, .REL_INT_EN_I, .TX_REQ_O, .TX_TYPE_O, .TX_BUS_RELEASE_FLAG_O, .TX_INT_O, .TX_DONE_I,
  .RX_VALID_I, .RX_READY_O, .RX_LAST_I, .STATE_O);
`default_nettype wire
